/* common/clb_pkg.sv */
// constants for the cache lock and buffer control block
// assumes one core clock; bit positions follow the cache control register layout
package clb_pkg;
    // ========================================
    // register map
    localparam logic [11:0] CACHE_CONTROL_OFS = 12'h002;
    localparam logic [31:0] CACHE_CONTROL_RST = 32'h0000_0000;
    localparam int CC_ON_BIT = 31;
    localparam int CC_SB_ON_BIT = 29;
    localparam int CC_KEEP_BIT = 28;
    localparam int CC_LOCK_BIT = 27;
    localparam int CC_INVAL_BIT = 24;
    // writable bits: 31, 29, 28, 27, 24, 10, 9:8, 5
    localparam logic [31:0] CC_WMASK = 32'hb900_0720;
    // ========================================
    // geometry
    localparam int NUM_WAYS = 4;
    localparam int NUM_SETS = 128;
    localparam int SET_W = 7;
    localparam int SB_DEPTH = 4;
    // ========================================
    // access and bus kinds
    typedef enum logic [1:0] {CLB_REG_NONE, CLB_REG_WR, CLB_REG_DBG_WR, CLB_REG_DBG_RD} clb_reg_op_t;
    typedef enum logic [1:0] {CLB_BUS_IDLE, CLB_BUS_PUSH, CLB_BUS_STORE, CLB_BUS_FILL} clb_bus_kind_t;
    typedef enum {CLB_IDLE, CLB_INVAL, CLB_DRAIN_FILL, CLB_DRAIN_SYNC, CLB_PUSH_CMD} clb_state_t;
endpackage : clb_pkg

/* rtl/clb_cache_ctrl.sv */
// cache control register, way allocation, line state and push/store buffer drain
// assumes the pipeline and bus controller share core_clk; bus cycles complete on bus_done
//
// Behaviour
// - buffered writes go out on next bus cycle
// - fill waits until push and store empty
// - sync events drain both buffers first
// - half lock protects ways zero and one
// - locked allocation prefers way two first
// - locked ways still take write hits
// - never allocate into locked ways
// - copyback write hit sets modified
// - core writes register, debug reads writes
// - reset clears control register
// - reset leaves line state untouched
// - enable bit gates cache operation
// - store buffer off writes go direct
// - store buffer on defers imprecise writes
// - precise inhibited writes bypass store buffer
// - push invalidates line when keep clear
// - push keeps line valid when set
// - unlocked lowest invalid, round robin four
// - locked full set round robin two
// - invalidate all walks sets, self clears
module clb_cache_ctrl
    import clb_pkg::*;
#(
    parameter int SBD = SB_DEPTH
) (
    input wire logic core_clk,             // core clock
    input wire logic rstn,                 // async reset, active low
    input wire logic [1:0] reg_op,         // register operation (clb_reg_op_t)
    input wire logic [11:0] reg_addr,      // control register number
    input wire logic [31:0] reg_wdata,     // register write data
    output logic [31:0] reg_rdata,         // debug read data
    input wire logic acc_req,              // pipeline access request
    input wire logic acc_wr,               // access is a write
    input wire logic acc_copyback,         // region is copyback
    input wire logic acc_cacheable,        // region is cacheable
    input wire logic acc_precise,          // region is precise mode
    input wire logic [SET_W-1:0] acc_set,  // set index
    input wire logic [NUM_WAYS-1:0] acc_hit, // tag hit per way
    input wire logic [31:0] acc_data,      // write data
    input wire logic sync_req,             // supervisor op, nop or exception
    input wire logic push_req,             // line push instruction
    input wire logic [SET_W-1:0] push_set, // set for line push
    input wire logic [1:0] push_way,       // way for line push
    input wire logic bus_done,             // external bus cycle terminated
    output logic stall,                    // pipeline stall
    output logic bus_req,                  // external bus request
    output logic [1:0] bus_kind,           // clb_bus_kind_t
    output logic [31:0] bus_wdata,         // bus write data
    output logic [1:0] alloc_way,          // way chosen for fill
    output logic cache_on                  // cache enabled
);
    // ========================================
    // state
    logic [31:0] ctl_r;
    logic [NUM_WAYS-1:0] valid_r [NUM_SETS];
    logic [NUM_WAYS-1:0] mod_r [NUM_SETS];
    logic [1:0] rr_r;
    logic [SET_W-1:0] inv_idx_r;
    logic [31:0] sb_data_r [SBD];
    logic [1:0] sb_rd_r, sb_wr_r;
    logic [2:0] sb_cnt_r;
    logic push_full_r;
    logic [31:0] push_data_r;
    logic bus_busy_r;
    logic [1:0] bus_kind_r;
    logic [31:0] bus_wdata_r;
    logic stall_r;
    logic [31:0] reg_rdata_r;
    logic [1:0] alloc_way_r;
    clb_state_t st_r, st_nxt;

    // ========================================
    // decode
    wire logic sel_cc = (reg_addr == CACHE_CONTROL_OFS);
    wire logic cc_wr = sel_cc && (reg_op == CLB_REG_WR || reg_op == CLB_REG_DBG_WR);
    wire logic cc_rd = sel_cc && (reg_op == CLB_REG_DBG_RD);
    wire logic en = ctl_r[CC_ON_BIT];
    wire logic sb_on = ctl_r[CC_SB_ON_BIT];
    wire logic locked = ctl_r[CC_LOCK_BIT];
    wire logic keep = ctl_r[CC_KEEP_BIT];
    wire logic [NUM_WAYS-1:0] set_v = valid_r[acc_set];
    wire logic any_hit = |(acc_hit & set_v);
    wire logic miss_fill = en && acc_req && acc_cacheable && !any_hit && (!acc_wr || acc_copyback);
    wire logic bufs_empty = (sb_cnt_r == 3'd0) && !push_full_r && !bus_busy_r;
    wire logic imprecise_wr = acc_req && acc_wr && !acc_precise && !(acc_cacheable && acc_copyback);
    wire logic to_sb = sb_on && imprecise_wr && st_r == CLB_IDLE;
    wire logic sb_full = (sb_cnt_r == 3'(SBD));
    wire logic direct_wr = acc_req && acc_wr && !to_sb && !(en && acc_cacheable && acc_copyback);

    function automatic logic [1:0] pick_way(input logic [NUM_WAYS-1:0] v, input logic lk, input logic [1:0] rr);
        logic [1:0] w;
        w = lk ? {1'b1, rr[1]} : rr;
        if (lk) begin
            if (!v[2]) w = 2'd2;
            else if (!v[3]) w = 2'd3;
        end else begin
            for (int i = NUM_WAYS - 1; i >= 0; i--) begin
                if (!v[i]) w = 2'(i);
            end
        end
        return w;
    endfunction : pick_way
    wire logic [1:0] victim = pick_way(set_v, locked, rr_r);
    wire logic set_full = locked ? (set_v[2] && set_v[3]) : (&set_v);
    wire logic victim_dirty = set_full && mod_r[acc_set][victim];

    // ========================================
    // sequencing
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            CLB_IDLE: begin
                if (ctl_r[CC_INVAL_BIT]) st_nxt = CLB_INVAL;
                else if (sync_req) st_nxt = CLB_DRAIN_SYNC;
                else if (push_req) st_nxt = CLB_PUSH_CMD;
                else if (miss_fill) st_nxt = CLB_DRAIN_FILL;
            end
            CLB_INVAL: if (inv_idx_r == SET_W'(NUM_SETS - 1)) st_nxt = CLB_IDLE;
            CLB_DRAIN_FILL: if (bus_done && bus_kind_r == CLB_BUS_FILL) st_nxt = CLB_IDLE;
            CLB_DRAIN_SYNC: if (bufs_empty) st_nxt = CLB_IDLE;
            CLB_PUSH_CMD: st_nxt = CLB_IDLE;
        endcase
    end

    wire logic start_fill = st_r == CLB_DRAIN_FILL && bufs_empty && !bus_busy_r;
    wire logic sb_push = to_sb && !sb_full;
    wire logic sb_pop = !bus_busy_r && !push_full_r && sb_cnt_r != 3'd0 && st_r != CLB_INVAL;
    wire logic push_go = !bus_busy_r && push_full_r;
    wire logic direct_go = !bus_busy_r && !push_full_r && sb_cnt_r == 3'd0 && direct_wr && st_r == CLB_IDLE;
    wire logic [1:0] next_kind = push_go ? CLB_BUS_PUSH : (start_fill ? CLB_BUS_FILL : CLB_BUS_STORE);
    wire logic [31:0] next_data = push_go ? push_data_r : (sb_pop ? sb_data_r[sb_rd_r] : acc_data);
    wire logic launch = push_go || sb_pop || start_fill || direct_go;
    wire logic stall_nxt = (st_nxt != CLB_IDLE) || (to_sb && sb_full) || (direct_wr && !direct_go);

    // ========================================
    // registers
    // reset and core/debug access
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= CACHE_CONTROL_RST;
            reg_rdata_r <= 32'h0000_0000;
        end else begin
            if (cc_wr) ctl_r <= reg_wdata & CC_WMASK;
            else if (st_r == CLB_INVAL && st_nxt == CLB_IDLE) ctl_r[CC_INVAL_BIT] <= 1'b0;
            if (cc_rd) reg_rdata_r <= ctl_r;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= CLB_IDLE;
            rr_r <= 2'd0;
            inv_idx_r <= '0;
            stall_r <= 1'b0;
            alloc_way_r <= 2'd0;
        end else begin
            st_r <= st_nxt;
            stall_r <= stall_nxt;
            inv_idx_r <= (st_r == CLB_INVAL) ? inv_idx_r + SET_W'(1) : '0;
            if (start_fill) begin
                alloc_way_r <= victim;
                // advance counter modulo 4 or 2
                if (set_full) rr_r <= locked ? {~rr_r[1], 1'b0} : rr_r + 2'd1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (st_r == CLB_INVAL) begin
            valid_r[inv_idx_r] <= '0;
            mod_r[inv_idx_r] <= '0;
        end else if (st_r == CLB_PUSH_CMD) begin
            mod_r[push_set][push_way] <= 1'b0;
            if (!keep) valid_r[push_set][push_way] <= 1'b0;
        end else if (start_fill) begin
            valid_r[acc_set][victim] <= 1'b1;
            mod_r[acc_set][victim] <= acc_wr;
        end else if (en && acc_req && acc_wr && any_hit && acc_copyback && st_r == CLB_IDLE) begin
            // write hits update locked ways too
            mod_r[acc_set] <= mod_r[acc_set] | (acc_hit & set_v);
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sb_rd_r <= 2'd0;
            sb_wr_r <= 2'd0;
            sb_cnt_r <= 3'd0;
        end else begin
            if (sb_push) sb_wr_r <= sb_wr_r + 2'd1;
            if (sb_pop) sb_rd_r <= sb_rd_r + 2'd1;
            sb_cnt_r <= sb_cnt_r + 3'(sb_push) - 3'(sb_pop);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sb_push) sb_data_r[sb_wr_r] <= acc_data;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus_busy_r <= 1'b0;
            bus_kind_r <= CLB_BUS_IDLE;
            bus_wdata_r <= 32'h0000_0000;
            push_full_r <= 1'b0;
            push_data_r <= 32'h0000_0000;
        end else begin
            if (launch) begin
                bus_busy_r <= 1'b1;
                bus_kind_r <= next_kind;
                bus_wdata_r <= next_data;
            end else if (bus_done) begin
                bus_busy_r <= 1'b0;
                bus_kind_r <= CLB_BUS_IDLE;
            end
            // a new push wins over the drain of the old one
            if ((start_fill && victim_dirty) || (st_r == CLB_PUSH_CMD && mod_r[push_set][push_way])) begin
                push_full_r <= 1'b1;
                push_data_r <= acc_data;
            end else if (push_go) begin
                push_full_r <= 1'b0;
            end
        end
    end

    // ========================================
    // outputs
    assign reg_rdata = reg_rdata_r;
    assign stall = stall_r;
    assign bus_req = bus_busy_r;
    assign bus_kind = bus_kind_r;
    assign bus_wdata = bus_wdata_r;
    assign alloc_way = alloc_way_r;
    assign cache_on = ctl_r[CC_ON_BIT];

    // ========================================
    // checks
    sequence s_sync_seen;
        st_r == CLB_IDLE && sync_req && !ctl_r[CC_INVAL_BIT];
    endsequence
    sync_drains_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_sync_seen |=> st_r == CLB_DRAIN_SYNC) else $error("sync did not start drain");
    fill_waits_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_fill |-> sb_cnt_r == 3'd0 && !push_full_r) else $error("fill started with pending writes");
    reset_clear_a: assert property (@(posedge core_clk)
        $rose(rstn) |-> ctl_r == 32'h0000_0000) else $error("control not cleared by reset");
    lock_alloc_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_fill && locked |=> alloc_way_r[1]) else $error("allocation into locked way");
    lock_way2_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_fill && locked && !set_v[2] |=> alloc_way_r == 2'd2) else $error("way two not preferred");
    sb_fill_a: assert property (@(posedge core_clk) disable iff (!rstn)
        sb_push && !sb_pop |=> sb_cnt_r == $past(sb_cnt_r) + 3'd1) else $error("store buffer count wrong");
    sb_bypass_a: assert property (@(posedge core_clk) disable iff (!rstn)
        acc_req && acc_wr && acc_precise |-> !sb_push) else $error("precise write entered store buffer");
    sb_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !sb_on |-> !sb_push) else $error("store buffer used while off");
    inval_done_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r == CLB_INVAL && inv_idx_r == SET_W'(NUM_SETS - 1) |=> !ctl_r[CC_INVAL_BIT] || $past(cc_wr))
        else $error("invalidate bit not cleared");
    drain_next_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !bus_busy_r && sb_cnt_r != 3'd0 && st_r != CLB_INVAL |=> bus_req) else $error("buffer not drained");
    push_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
        push_go |=> bus_req && bus_kind_r == CLB_BUS_PUSH) else $error("push buffer not drained");
    order_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
        sb_pop |=> bus_kind_r == CLB_BUS_STORE && bus_wdata_r == $past(sb_data_r[sb_rd_r]))
        else $error("store buffer retired out of order");
    fill_end_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r == CLB_DRAIN_FILL && bus_done && bus_kind_r == CLB_BUS_FILL |=> st_r == CLB_IDLE)
        else $error("fill did not release pipeline");
    sync_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r == CLB_DRAIN_SYNC && st_nxt == CLB_IDLE |-> sb_cnt_r == 3'd0 && !push_full_r && !bus_busy_r)
        else $error("sync ended with pending writes");
    low_way_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_fill && !locked && !set_v[0] |=> alloc_way_r == 2'd0) else $error("lowest invalid way skipped");
    rr_four_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_fill && !locked && set_full |=> rr_r == $past(rr_r) + 2'd1) else $error("round robin not advanced");
    rr_two_a: assert property (@(posedge core_clk) disable iff (!rstn)
        start_fill && locked && set_full |=> alloc_way_r[1] && alloc_way_r[0] == $past(rr_r[1])
        && rr_r[1] != $past(rr_r[1])) else $error("locked round robin wrong");
    off_no_fill_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r == CLB_IDLE && !en |=> st_r != CLB_DRAIN_FILL) else $error("fill while cache off");
    inval_stall_a: assert property (@(posedge core_clk) disable iff (!rstn)
        st_r == CLB_INVAL |-> stall) else $error("access not stalled during invalidate");
    sequence s_push_cmd;
        st_r == CLB_PUSH_CMD && mod_r[push_set][push_way];
    endsequence
    push_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_push_cmd |=> push_full_r) else $error("modified line not pushed");
    sequence s_copyback_hit;
        en && acc_req && acc_wr && acc_copyback && any_hit && st_r == CLB_IDLE;
    endsequence
    hit_mod_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_copyback_hit |=> (mod_r[$past(acc_set)] & $past(acc_hit & set_v)) == $past(acc_hit & set_v))
        else $error("write hit did not mark line modified");
endmodule : clb_cache_ctrl

/* tb/cache_lock_and_buffer_control_bench.sv */
// self-checking bench for the cache control block
// assumes clb_bus_model answers the external bus
module cache_lock_and_buffer_control_bench;
    import clb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [1:0] kind; logic [31:0] data; bit ck; bit cd;} clb_note_t;
    logic core_clk, rstn, acc_req, acc_wr, acc_copyback, acc_cacheable, acc_precise;
    logic sync_req, push_req, bus_done, stall, bus_req, cache_on;
    logic [1:0] reg_op, push_way, bus_kind, alloc_way;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, acc_data, bus_wdata, seed, v, d;
    logic [6:0] acc_set, push_set;
    logic [3:0] acc_hit, bus_wait;
    int miscompares, comparisons, n;
    clb_note_t notes[$];
    clb_note_t m;
    clb_cache_ctrl DUT (.core_clk, .rstn, .reg_op, .reg_addr, .reg_wdata, .reg_rdata, .acc_req, .acc_wr,
        .acc_copyback, .acc_cacheable, .acc_precise, .acc_set, .acc_hit, .acc_data, .sync_req, .push_req,
        .push_set, .push_way, .bus_done, .stall, .bus_req, .bus_kind, .bus_wdata, .alloc_way, .cache_on);
    clb_bus_model bus (.core_clk, .rstn, .bus_req, .wait_cycles(bus_wait), .bus_done);
    // ========================================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        check(notes.size(), 0);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask : tick
    task automatic reg_wr(input clb_reg_op_t op, input logic [11:0] a, input logic [31:0] x);
        reg_op = op;
        reg_addr = a;
        reg_wdata = x;
        tick();
        reg_op = CLB_REG_NONE;
        tick();
    endtask : reg_wr
    task automatic reg_chk(input logic [31:0] exp);
        reg_op = CLB_REG_DBG_RD;
        reg_addr = CACHE_CONTROL_OFS;
        tick();
        reg_op = CLB_REG_NONE;
        check(reg_rdata, exp);
        tick();
    endtask : reg_chk
    // a hang here is caught by the watchdog
    task automatic wait_idle(input bit bus_too);
        do begin
            tick();
        end while (stall === 1'b1 || (bus_too && bus_req === 1'b1));
    endtask : wait_idle
    // access held while stalled; n counts cycles until taken
    task automatic access(input logic [3:0] kd, input logic [3:0] hit, input logic [6:0] set,
        input logic [31:0] x, output int n);
        acc_req = 1'b1;
        {acc_wr, acc_copyback, acc_cacheable, acc_precise} = kd;
        acc_hit = hit;
        acc_set = set;
        acc_data = x;
        n = 0;
        do begin
            tick();
            n++;
        end while (stall === 1'b1);
        acc_req = 1'b0;
        tick();
    endtask : access
    task automatic store(input int k);
        repeat (k) begin
            d = $random(seed);
            notes.push_back('{CLB_BUS_STORE, d, 1'b1, 1'b1});
            access(4'b1000, 4'h0, 7'h05, d, n);
            check(n, 1);
        end
    endtask : store
    // second write finds the bus busy and must wait, as nothing buffers it
    task automatic direct(input logic [3:0] kd);
        repeat (2) begin
            d = $random(seed);
            notes.push_back('{CLB_BUS_STORE, d, 1'b1, 1'b1});
            access(kd, 4'h0, 7'h06, d, n);
        end
        check(n > 1, 1'b1);
    endtask : direct
    task automatic fill(input logic [6:0] set, input logic [1:0] w);
        notes.push_back('{CLB_BUS_FILL, 32'h0, 1'b1, 1'b0});
        access(4'b0010, 4'h0, set, 32'h0, n);
        check(alloc_way, w);
    endtask : fill
    task automatic hit_push(input logic [6:0] set, input logic [1:0] w);
        access(4'b1110, 4'h1 << w, set, $random(seed), n);
        notes.push_back('{CLB_BUS_PUSH, 32'h0, 1'b1, 1'b0});
        push_set = set;
        push_way = w;
        push_req = 1'b1;
        tick();
        push_req = 1'b0;
        repeat (3) tick();
        wait_idle(1'b1);
    endtask : hit_push
    // ========================================
    // bus launch monitor
    always @(posedge bus_req) begin
        #1;
        if (notes.size() == 0) begin
            check(bus_req, 1'b0);
        end else begin
            m = notes.pop_front();
            if (m.ck) check(bus_kind, m.kind);
            if (m.cd) check(bus_wdata, m.data);
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end
    // ========================================
    // main sequence
    initial begin
        seed = 32'hdefe4e9d;
        {rstn, acc_req, acc_wr, acc_copyback, acc_cacheable, acc_precise, sync_req, push_req} = '0;
        {reg_op, reg_addr, reg_wdata, acc_set, acc_hit, acc_data, push_set, push_way} = '0;
        bus_wait = 4'h0;
        miscompares = 0;
        comparisons = 0;
        repeat (10) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        reg_chk(32'h0);
        check(cache_on, 1'b0);
        reg_wr(CLB_REG_WR, CACHE_CONTROL_OFS, 32'h0100_0000);
        check(stall, 1'b1);
        wait_idle(1'b0);
        reg_chk(32'h0);
        v = $random(seed) & CC_WMASK & 32'hfeff_ffff;
        reg_wr(CLB_REG_DBG_WR, CACHE_CONTROL_OFS, v);
        reg_wr(CLB_REG_WR, 12'h003, ~v);
        reg_chk(v);
        check(cache_on, v[31]);
        reg_wr(CLB_REG_WR, CACHE_CONTROL_OFS, 32'ha000_0000);
        bus_wait = 4'h6;
        store(4);
        for (int i = 0; i < 4; i++) fill(7'h05, i[1:0]);
        store(2);
        sync_req = 1'b1;
        tick();
        sync_req = 1'b0;
        wait_idle(1'b0);
        check(bus_req, 1'b0);
        check(notes.size(), 0);
        reg_wr(CLB_REG_WR, CACHE_CONTROL_OFS, 32'h8000_0000);
        direct(4'b1000);
        hit_push(7'h05, 2'd0);
        fill(7'h05, 2'd0);
        reg_wr(CLB_REG_WR, CACHE_CONTROL_OFS, 32'ha000_0000);
        direct(4'b1001);
        reg_wr(CLB_REG_WR, CACHE_CONTROL_OFS, 32'h9000_0000);
        hit_push(7'h05, 2'd0);
        hit_push(7'h05, 2'd0);
        reg_wr(CLB_REG_WR, CACHE_CONTROL_OFS, 32'h8800_0000);
        fill(7'h09, 2'd2);
        fill(7'h09, 2'd3);
        notes.push_back('{CLB_BUS_FILL, 32'h0, 1'b1, 1'b0});
        access(4'b0010, 4'h0, 7'h09, 32'h0, n);
        check(alloc_way[1], 1'b1);
        hit_push(7'h05, 2'd1);
        rstn = 1'b0;
        repeat (2) tick();
        rstn = 1'b1;
        reg_wr(CLB_REG_WR, CACHE_CONTROL_OFS, 32'h8000_0000);
        hit_push(7'h05, 2'd2);
        end_of_test();
    end
endmodule : cache_lock_and_buffer_control_bench

/* tb/clb_bus_model.sv */
// bus controller stand-in: ends each outstanding bus cycle after wait_cycles
// assumes bus_req is registered and drops on the edge after bus_done
module clb_bus_model (
    input wire logic core_clk,          // core clock
    input wire logic rstn,              // async reset, active low
    input wire logic bus_req,           // bus cycle outstanding
    input wire logic [3:0] wait_cycles, // answer delay in cycles
    output logic bus_done               // one-cycle termination
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    int cnt;
    // ========================================
    // termination
    // one termination per cycle
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy = 1'b0;
            cnt = -1;
            bus_done <= 1'b0;
        end else begin
            bus_done <= #1 1'b0;
            if (!bus_req) begin
                busy = 1'b0;
            end else if (!busy) begin
                busy = 1'b1;
                cnt = wait_cycles;
            end else if (cnt > 0) begin
                cnt--;
            end
            if (busy && cnt == 0) begin
                bus_done <= #1 1'b1;
                cnt = -1;
            end
        end
    end
endmodule : clb_bus_model
